// ### include/rpwsfr_pkg.sv
// Constants and types for the posted-write status and frozen-read block
package rpwsfr_pkg;

   // ==========================================================
   // Timing
   // Bus clock rate and the slow timekeeping rate
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned SLOW_FREQ_HZ = 32_768;
   // Longest whole number of bus cycles inside one slow period
   localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / SLOW_FREQ_HZ;
   localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
   localparam logic [11:0] TICK_RST = 12'h000;

   // ==========================================================
   // Register byte offsets on the bus
   localparam int ADR_W = 8;
   localparam logic [7:0] PEND_OFS = 8'h00;
   localparam logic [7:0] CAPST_OFS = 8'h04;
   localparam logic [7:0] FRZ_OFS = 8'h08;
   localparam logic [7:0] GWY_OFS = 8'h0C;
   localparam logic [7:0] CFG3_OFS = 8'h10;
   localparam logic [7:0] CFG2_OFS = 8'h14;
   localparam logic [7:0] SR3_OFS = 8'h18;
   localparam logic [7:0] IRQ_ST_OFS = 8'h1C;
   localparam logic [7:0] IRQ_MSK_OFS = 8'h20;
   localparam logic [2:0] CAP_OFS_HI = 3'h2;
   localparam logic [2:0] CAP_LAST_IDX = 3'h4;

   // ==========================================================
   // Field positions
   localparam int PEND_CLR_BIT = 0;
   localparam int PEND_CFG2_BIT = 1;
   localparam int PEND_CFG3_BIT = 2;
   localparam int PTR_LSB = 9;
   localparam int PTR_MSB = 10;
   localparam int NUM_CAP = 5;
   // Channels that carry a capture input; channel one has none
   localparam logic [4:0] CAP_PRESENT = 5'h1D;
   localparam int IRQ_CFG3_BIT = 0;
   localparam int IRQ_CFG2_BIT = 1;
   localparam int IRQ_CLR_BIT = 2;
   localparam int IRQ_CAP_BIT = 3;
   localparam int IRQ_W = 4;

   // ==========================================================
   // Keys and values after reset
   localparam logic [15:0] GWY_PTR_KEY = 16'h9376;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [4:0] CAP_RST = 5'h00;
   localparam logic [3:0] IRQ_RST = 4'h0;

   // ==========================================================
   // Triple-read position
   typedef enum logic [1:0] {
      PTR_FIRST = 2'b00,
      PTR_SECOND = 2'b01,
      PTR_THIRD = 2'b10
   } rpwsfr_ptr_t;

endpackage

// ### hw/rpwsfr_posted_slot.sv
// One posted-write slot that waits for the next slow-domain tick
`timescale 1ns/1ps

module rpwsfr_posted_slot #(
   parameter bit MERGE = 1'b0
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic post_in,
   input wire logic [15:0] data_in,
   input wire logic tick_in,
   output logic accepted_out,
   output logic exec_out,
   output logic pending_out,
   output logic [15:0] data_out
);

   // ==========================================================
   // Acceptance
   // A slot that frees in this very cycle may take a new posting
   assign exec_out = tick_in & pending_out;
   assign accepted_out = post_in & (~pending_out | exec_out | MERGE);

   // Merged data keeps every earlier clearance still queued
   logic [15:0] next_data;
   assign next_data = (MERGE && pending_out && !exec_out) ?
                      (data_out | data_in) : data_in;

   // ==========================================================
   // Pending flag and held data
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pending_out <= 1'b0;
         data_out <= rpwsfr_pkg::WORD_RST;
      end else if (accepted_out) begin
         pending_out <= 1'b1;
         data_out <= next_data;
      end else if (exec_out) begin
         pending_out <= 1'b0;
      end
   end

endmodule

// ### hw/rpwsfr_top.sv
// Posted-write status, capture unread status and triple frozen read
//
// Notes on behaviour
// - Pending flag for strobe config three writes
// - Pending flag for capture config two writes
// - Bit 0 flags queued interrupt-source clearances
// - Clearances while pending merge into queued one
// - Status holds unread flags of channels 0,2,3,4
// - First instance reads that address as reset
// - Bits 10:9 hold next triple-read position
// - Gateway key 0x9376 zeroes the read pointer
// - First read: live low word, snapshot rest
// - Second read returns middle word snapshot
// - Unread flags sticky, set by slow domain
`timescale 1ns/1ps

module rpwsfr_top #(
   // One for the second clock instance, zero for the first
   parameter bit HAS_CAPTURE_STATUS = 1'b1
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [4:0] capture_pin_in,
   output logic [15:0] strobe_cfg3_out,
   output logic [15:0] capture_cfg2_out,
   output logic irq_out
);

   // ==========================================================
   // Slow-domain tick
   // The slow side is modelled as a one-cycle tick on the bus clock,
   // so completion needs no separate crossing back
   logic [11:0] tick_cnt;
   logic tick;
   assign tick = (tick_cnt == rpwsfr_pkg::TICK_LAST);

   // Divider free-runs from reset
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || tick) begin
         tick_cnt <= rpwsfr_pkg::TICK_RST;
      end else begin
         tick_cnt <= tick_cnt + 12'h001;
      end
   end

   // ==========================================================
   // Counter, low word first
   logic [15:0] counter_low_word, counter_middle_word, counter_upper_word;
   logic [47:0] next_count;
   assign next_count = {counter_upper_word, counter_middle_word,
                        counter_low_word} + 48'h000000000001;

   // All three words move on one edge, so a single read is coherent
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         counter_low_word <= rpwsfr_pkg::WORD_RST;
         counter_middle_word <= rpwsfr_pkg::WORD_RST;
         counter_upper_word <= rpwsfr_pkg::WORD_RST;
      end else if (tick) begin
         {counter_upper_word, counter_middle_word,
          counter_low_word} <= next_count;
      end
   end

   // ==========================================================
   // Bus request decode
   logic req, rd_take, wr_take;
   logic [15:0] wdata;
   assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign rd_take = req & ~wb_we_in;
   // Both low byte lanes must be on; a partial write is ignored
   assign wr_take = req & wb_we_in & (wb_sel_in[1:0] == 2'b11);
   assign wdata = wb_dat_in[15:0];

   logic sel_pend, sel_capst, sel_frz, sel_gwy, sel_cfg3, sel_cfg2;
   logic sel_sr3, sel_irq_st, sel_irq_msk, sel_cap;
   logic [2:0] cap_idx;
   assign sel_pend = (wb_adr_in == rpwsfr_pkg::PEND_OFS);
   assign sel_capst = (wb_adr_in == rpwsfr_pkg::CAPST_OFS);
   assign sel_frz = (wb_adr_in == rpwsfr_pkg::FRZ_OFS);
   assign sel_gwy = (wb_adr_in == rpwsfr_pkg::GWY_OFS);
   assign sel_cfg3 = (wb_adr_in == rpwsfr_pkg::CFG3_OFS);
   assign sel_cfg2 = (wb_adr_in == rpwsfr_pkg::CFG2_OFS);
   assign sel_sr3 = (wb_adr_in == rpwsfr_pkg::SR3_OFS);
   assign sel_irq_st = (wb_adr_in == rpwsfr_pkg::IRQ_ST_OFS);
   assign sel_irq_msk = (wb_adr_in == rpwsfr_pkg::IRQ_MSK_OFS);
   assign cap_idx = wb_adr_in[4:2];
   assign sel_cap = (wb_adr_in[7:5] == rpwsfr_pkg::CAP_OFS_HI) &&
                    (wb_adr_in[1:0] == 2'b00) &&
                    (cap_idx <= rpwsfr_pkg::CAP_LAST_IDX);

   // ==========================================================
   // Posted slots
   logic cfg3_pend, cfg2_pend, clr_pend;
   logic cfg3_exec, cfg2_exec, clr_exec;
   logic [15:0] cfg3_data, cfg2_data, clr_data;
   // A write while pending is dropped unless the slot frees in that cycle; the flag stays up
   rpwsfr_posted_slot #(.MERGE(1'b0)) u_cfg3_slot (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .post_in(wr_take & sel_cfg3), .data_in(wdata), .tick_in(tick),
      .accepted_out(), .exec_out(cfg3_exec),
      .pending_out(cfg3_pend), .data_out(cfg3_data)
   );
   rpwsfr_posted_slot #(.MERGE(1'b0)) u_cfg2_slot (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .post_in(wr_take & sel_cfg2), .data_in(wdata), .tick_in(tick),
      .accepted_out(), .exec_out(cfg2_exec),
      .pending_out(cfg2_pend), .data_out(cfg2_data)
   );

   // Clearances are write-one bitmaps, so OR-merging loses none
   rpwsfr_posted_slot #(.MERGE(1'b1)) u_clr_slot (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .post_in(wr_take & sel_sr3), .data_in(wdata), .tick_in(tick),
      .accepted_out(), .exec_out(clr_exec),
      .pending_out(clr_pend), .data_out(clr_data)
   );

   // Executed configuration takes effect on the slow tick
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         strobe_cfg3_out <= rpwsfr_pkg::WORD_RST;
         capture_cfg2_out <= rpwsfr_pkg::WORD_RST;
      end else begin
         if (cfg3_exec) begin
            strobe_cfg3_out <= cfg3_data;
         end
         if (cfg2_exec) begin
            capture_cfg2_out <= cfg2_data;
         end
      end
   end

   // ==========================================================
   // Capture inputs
   logic [4:0] pin_meta, pin_sync, pin_prev;
   logic [4:0] edge_hold, cap_event, cap_rd, unread;
   logic [15:0] interrupt_source_status_three;
   logic [15:0] cap_word [rpwsfr_pkg::NUM_CAP];

   // Pins cross in by two flops; the second stage and its one-cycle delayed copy are read
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pin_meta <= rpwsfr_pkg::CAP_RST;
         pin_sync <= rpwsfr_pkg::CAP_RST;
         pin_prev <= rpwsfr_pkg::CAP_RST;
      end else begin
         pin_meta <= capture_pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < rpwsfr_pkg::NUM_CAP; ch++) begin : g_cap
         if (rpwsfr_pkg::CAP_PRESENT[ch]) begin : g_on
            logic rise;
            // Capture is armed by the channel's enable in config two
            assign rise = pin_sync[ch] & ~pin_prev[ch] &
                          capture_cfg2_out[ch];
            assign cap_event[ch] = tick & edge_hold[ch];
            assign cap_rd[ch] = rd_take & sel_cap &
                                (cap_idx == 3'(ch));

            // An edge waits for the slow tick before it is taken
            always_ff @(posedge ref_clk_in) begin
               if (sys_rst_in) begin
                  edge_hold[ch] <= 1'b0;
                  cap_word[ch] <= rpwsfr_pkg::WORD_RST;
                  unread[ch] <= 1'b0;
               end else begin
                  if (rise) begin
                     edge_hold[ch] <= 1'b1;
                  end else if (tick) begin
                     edge_hold[ch] <= 1'b0;
                  end
                  // A new snapshot beats a read of the old one
                  if (cap_event[ch]) begin
                     cap_word[ch] <= counter_low_word;
                     unread[ch] <= 1'b1;
                  end else if (cap_rd[ch]) begin
                     unread[ch] <= 1'b0;
                  end
               end
            end
         end else begin : g_off
            assign cap_event[ch] = 1'b0;
            assign cap_rd[ch] = 1'b0;
            assign edge_hold[ch] = 1'b0;
            assign unread[ch] = 1'b0;
            assign cap_word[ch] = rpwsfr_pkg::WORD_RST;
         end
      end
   endgenerate

   // ==========================================================
   // Interrupt sources three, cleared only by executed postings
   logic [15:0] sr3_set;
   assign sr3_set = {11'h000, cap_event};

   // A source that fires on the clearing tick stays set
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         interrupt_source_status_three <= rpwsfr_pkg::WORD_RST;
      end else if (clr_exec) begin
         interrupt_source_status_three <=
            (interrupt_source_status_three & ~clr_data) | sr3_set;
      end else begin
         interrupt_source_status_three <=
            interrupt_source_status_three | sr3_set;
      end
   end

   // ==========================================================
   // Triple read of the frozen-count port
   rpwsfr_pkg::rpwsfr_ptr_t triple_read_pointer, next_ptr;
   logic [15:0] snap_mid, snap_up, frz_word;
   logic frz_rd, key_hit;
   assign frz_rd = rd_take & sel_frz;
   assign key_hit = wr_take & sel_gwy & (wdata == rpwsfr_pkg::GWY_PTR_KEY);

   // Data and next position for a read at the present position
   always_comb begin
      frz_word = counter_low_word;
      next_ptr = rpwsfr_pkg::PTR_FIRST;
      unique case (triple_read_pointer)
         rpwsfr_pkg::PTR_FIRST: begin
            frz_word = counter_low_word;
            next_ptr = rpwsfr_pkg::PTR_SECOND;
         end
         rpwsfr_pkg::PTR_SECOND: begin
            frz_word = snap_mid;
            next_ptr = rpwsfr_pkg::PTR_THIRD;
         end
         rpwsfr_pkg::PTR_THIRD: begin
            frz_word = snap_up;
            next_ptr = rpwsfr_pkg::PTR_FIRST;
         end
         default: begin
            frz_word = counter_low_word;
            next_ptr = rpwsfr_pkg::PTR_FIRST;
         end
      endcase
   end

   // Snapshot is taken from the same edge as the low word
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         triple_read_pointer <= rpwsfr_pkg::PTR_FIRST;
         snap_mid <= rpwsfr_pkg::WORD_RST;
         snap_up <= rpwsfr_pkg::WORD_RST;
      end else if (key_hit) begin
         triple_read_pointer <= rpwsfr_pkg::PTR_FIRST;
      end else if (frz_rd) begin
         triple_read_pointer <= next_ptr;
         if (triple_read_pointer == rpwsfr_pkg::PTR_FIRST) begin
            snap_mid <= counter_middle_word;
            snap_up <= counter_upper_word;
         end
      end
   end

   // ==========================================================
   // Interrupt status and mask
   logic [3:0] irq_status, irq_mask, irq_set, irq_clr;
   assign irq_set = {|cap_event, clr_exec, cfg2_exec, cfg3_exec};
   assign irq_clr = (wr_take & sel_irq_st) ? wdata[3:0] : 4'h0;
   assign irq_out = |(irq_status & irq_mask);

   // Write one clears; a simultaneous event keeps its bit
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         irq_status <= rpwsfr_pkg::IRQ_RST;
         irq_mask <= rpwsfr_pkg::IRQ_RST;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_take && sel_irq_msk) begin
            irq_mask <= wdata[3:0];
         end
      end
   end

   // ==========================================================
   // Read data
   logic [31:0] pend_word, capst_word, next_rd_data;
   always_comb begin
      pend_word = 32'h00000000;
      pend_word[rpwsfr_pkg::PEND_CFG3_BIT] = cfg3_pend;
      pend_word[rpwsfr_pkg::PEND_CFG2_BIT] = cfg2_pend;
      pend_word[rpwsfr_pkg::PEND_CLR_BIT] = clr_pend;
   end

   // Without the capture status the address reads its reset value
   always_comb begin
      capst_word = 32'h00000000;
      if (HAS_CAPTURE_STATUS) begin
         capst_word[4:0] = unread;
         capst_word[rpwsfr_pkg::PTR_MSB:rpwsfr_pkg::PTR_LSB] =
            triple_read_pointer;
      end
   end

   // Unmapped addresses answer with zero data, never an error
   assign next_rd_data =
      sel_pend ? pend_word :
      sel_capst ? capst_word :
      sel_frz ? {16'h0000, frz_word} :
      sel_cfg3 ? {16'h0000, strobe_cfg3_out} :
      sel_cfg2 ? {16'h0000, capture_cfg2_out} :
      sel_sr3 ? {16'h0000, interrupt_source_status_three} :
      sel_irq_st ? {28'h0000000, irq_status} :
      sel_irq_msk ? {28'h0000000, irq_mask} :
      sel_cap ? {16'h0000, cap_word[cap_idx]} :
      32'h00000000;

   // One wait state: ack and data come on the edge after the request
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= req;
         if (rd_take) begin
            wb_dat_out <= next_rd_data;
         end
      end
   end

endmodule

// ### verif/rpwsfr_top_asserts.sv
// Concurrent checks on the bus and configuration ports of the block
`timescale 1ns/1ps

module rpwsfr_top_asserts #(
   parameter bit HAS_CAPTURE_STATUS = 1'b1
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [4:0] capture_pin_in,
   input wire logic [15:0] strobe_cfg3_out,
   input wire logic [15:0] capture_cfg2_out,
   input wire logic irq_out
);
   // ==========================================================
   // Request decode; a request counts once, on the edge it is taken
   wire logic req_taken = wb_cyc_in && wb_stb_in && !wb_ack_out;
   wire logic rd_taken = req_taken && !wb_we_in;
   wire logic rd_pend = rd_taken && (wb_adr_in == rpwsfr_pkg::PEND_OFS);
   wire logic rd_capst = rd_taken && (wb_adr_in == rpwsfr_pkg::CAPST_OFS);
   wire logic key_wr = req_taken && wb_we_in && (wb_sel_in[1:0] == 2'h3)
      && (wb_adr_in == rpwsfr_pkg::GWY_OFS)
      && (wb_dat_in[15:0] == rpwsfr_pkg::GWY_PTR_KEY);

   // ==========================================================
   // Properties; one clock domain, so one default clocking
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_ack_next_cycle: assert property (req_taken |=> wb_ack_out)
      else $error("ack missing one cycle after request");
   a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (wb_ack_out |-> $past(req_taken))
      else $error("ack without request");
   a_read_data_holds: assert property (!rd_taken |=> $stable(wb_dat_out))
      else $error("read data moved without a read");
   a_unmapped_reads_zero: assert property
      (rd_taken && wb_adr_in == 8'h30 |=> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   a_pend_layout: assert property
      (rd_pend |=> wb_dat_out[31:3] == 29'h0)
      else $error("pending status has stray bits");
   a_capst_layout: assert property
      (HAS_CAPTURE_STATUS && rd_capst |=>
      wb_dat_out[31:11] == 21'h0 && wb_dat_out[8:5] == 4'h0
      && !wb_dat_out[1] && wb_dat_out[10:9] != 2'b11)
      else $error("capture status has stray bits");
   a_capst_reserved: assert property
      (!HAS_CAPTURE_STATUS && rd_capst |=> wb_dat_out == 32'h0)
      else $error("reserved status not at reset value");
   a_key_clears_ptr: assert property (HAS_CAPTURE_STATUS && key_wr
      ##[2:3] rd_capst |=> wb_dat_out[10:9] == 2'b00)
      else $error("pointer not zero after key");
   // A posted value lands on a slow tick, so it cannot move twice in a row
   a_cfg3_per_tick: assert property
      ($changed(strobe_cfg3_out) |=> $stable(strobe_cfg3_out)[*8])
      else $error("strobe config moved off a tick");
   a_cfg2_per_tick: assert property
      ($changed(capture_cfg2_out) |=> $stable(capture_cfg2_out)[*8])
      else $error("capture config moved off a tick");
endmodule

bind rpwsfr_top rpwsfr_top_asserts #(
   .HAS_CAPTURE_STATUS(HAS_CAPTURE_STATUS)
) rpwsfr_top_asserts_inst (
   .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
   .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .capture_pin_in(capture_pin_in), .strobe_cfg3_out(strobe_cfg3_out),
   .capture_cfg2_out(capture_cfg2_out), .irq_out(irq_out)
);

// ### verif/rpwsfr_test.sv
// Directed bench for the posted-write status and frozen-read block
`timescale 1ns/1ps

module rpwsfr_test;
   // ==========================================================
   // Stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [4:0] pins = 5'h00;
   logic [31:0] dat_a, dat_b, rdat, rdat_b;
   logic ack_a, irq_a;
   logic [15:0] cfg3_a, cfg2_a;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;

   // Second clock instance against first; both see the same bus
   rpwsfr_top #(.HAS_CAPTURE_STATUS(1'b1)) rpwsfr_top_inst (
      .ref_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(dat_a), .wb_ack_out(ack_a), .capture_pin_in(pins),
      .strobe_cfg3_out(cfg3_a), .capture_cfg2_out(cfg2_a), .irq_out(irq_a));
   rpwsfr_top #(.HAS_CAPTURE_STATUS(1'b0)) first_rpwsfr_top_inst (
      .ref_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
      .wb_dat_out(dat_b), .wb_ack_out(), .capture_pin_in(pins),
      .strobe_cfg3_out(), .capture_cfg2_out(), .irq_out());

   // ==========================================================
   // Clock and a hang guard well above three slow ticks
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   // ==========================================================
   // Tasks
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Classic cycle held until ack is sampled high, then released
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack_a !== 1'b1) @(posedge clk);
      rdat = dat_a;
      rdat_b = dat_b;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input string name);
      xfer(1'b0, a, 32'h0);
      check(name, rdat, exp);
   endtask
   // Irq is looked at one edge after the write, once it has landed
   task automatic irq_chk(input logic exp, input string name);
      @(posedge clk);
      check(name, {31'h0, irq_a}, {31'h0, exp});
   endtask
   // The slow tick period is fixed, so a fixed wait covers one tick
   task automatic wait_tick();
      repeat (3060) @(posedge clk);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(rpwsfr_pkg::PEND_OFS, 32'h0, "pending at reset");
      rd(rpwsfr_pkg::CAPST_OFS, 32'h0, "capture status at reset");
      check("reserved status", rdat_b, 32'h0);
      rd(8'h30, 32'h0, "unmapped read");
      // Second posting to config three is refused while one is pending
      xfer(1'b1, rpwsfr_pkg::CFG3_OFS, 32'h1234);
      xfer(1'b1, rpwsfr_pkg::CFG3_OFS, 32'h5678);
      xfer(1'b1, rpwsfr_pkg::CFG2_OFS, 32'h001D);
      rd(rpwsfr_pkg::PEND_OFS, 32'h6, "config pending");
      xfer(1'b1, rpwsfr_pkg::SR3_OFS, 32'h1);
      xfer(1'b1, rpwsfr_pkg::SR3_OFS, 32'h10);
      rd(rpwsfr_pkg::PEND_OFS, 32'h7, "clearance merged");
      check("strobe cfg early", {16'h0, cfg3_a}, 32'h0);
      wait_tick();
      rd(rpwsfr_pkg::PEND_OFS, 32'h0, "pending after tick");
      check("strobe cfg", {16'h0, cfg3_a}, 32'h1234);
      check("capture cfg", {16'h0, cfg2_a}, 32'h001D);
      rd(rpwsfr_pkg::CFG3_OFS, 32'h1234, "strobe cfg read");
      // Interrupt: raise through mask, clear by writing ones
      rd(rpwsfr_pkg::IRQ_ST_OFS, 32'h7, "irq status");
      irq_chk(1'b0, "irq all masked");
      xfer(1'b1, rpwsfr_pkg::IRQ_MSK_OFS, 32'h4);
      irq_chk(1'b1, "irq unmasked");
      xfer(1'b1, rpwsfr_pkg::IRQ_ST_OFS, 32'h4);
      irq_chk(1'b0, "irq after clear");
      rd(rpwsfr_pkg::IRQ_ST_OFS, 32'h3, "irq status left");
      xfer(1'b1, rpwsfr_pkg::IRQ_MSK_OFS, 32'hF);
      irq_chk(1'b1, "irq wide mask");
      xfer(1'b1, rpwsfr_pkg::IRQ_ST_OFS, 32'hF);
      irq_chk(1'b0, "irq all cleared");
      // Capture on channels zero and four
      pins <= 5'h11;
      wait_tick();
      rd(rpwsfr_pkg::CAPST_OFS, 32'h11, "unread set");
      check("reserved status", rdat_b, 32'h0);
      xfer(1'b1, rpwsfr_pkg::SR3_OFS, 32'h1F);
      rd(rpwsfr_pkg::PEND_OFS, 32'h1, "clearance pending");
      wait_tick();
      rd(rpwsfr_pkg::SR3_OFS, 32'h0, "sources cleared");
      rd(rpwsfr_pkg::CAPST_OFS, 32'h11, "unread sticky");
      xfer(1'b0, 8'h40, 32'h0);
      check("capture word", rdat, 32'h1);
      rd(rpwsfr_pkg::CAPST_OFS, 32'h10, "unread after read");
      // Triple read, key reset in mid-sequence, then a full sequence
      xfer(1'b0, rpwsfr_pkg::FRZ_OFS, 32'h0);
      check("live low word", rdat, 32'h3);
      rd(rpwsfr_pkg::CAPST_OFS, 32'h210, "pointer second");
      rd(rpwsfr_pkg::FRZ_OFS, 32'h0, "middle snapshot");
      rd(rpwsfr_pkg::CAPST_OFS, 32'h410, "pointer third");
      xfer(1'b1, rpwsfr_pkg::GWY_OFS, 32'h9376);
      rd(rpwsfr_pkg::CAPST_OFS, 32'h10, "pointer after key");
      xfer(1'b0, rpwsfr_pkg::FRZ_OFS, 32'h0);
      rd(rpwsfr_pkg::FRZ_OFS, 32'h0, "middle snapshot");
      rd(rpwsfr_pkg::FRZ_OFS, 32'h0, "upper snapshot");
      rd(rpwsfr_pkg::CAPST_OFS, 32'h10, "pointer wrapped");
      check("reserved status", rdat_b, 32'h0);
      irq_chk(1'b1, "irq from capture and clearance");
      // A reset in mid-run puts outputs and status back to zero
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check("strobe cfg after reset", {16'h0, cfg3_a}, 32'h0);
      check("irq after reset", {31'h0, irq_a}, 32'h0);
      rd(rpwsfr_pkg::CAPST_OFS, 32'h0, "capture status reset");
      summarize();
   end
endmodule
